// *** src/ebi_defines.vh ***
`ifndef EBI_DEFINES_VH
`define EBI_DEFINES_VH

// widths
`define EBI_ADR_W        26
`define EBI_ASI_W        4
`define EBI_DATA_W       32
`define EBI_BE_W         4
`define EBI_TT_W         8

// byte-lane enable codes (active low per lane)
`define EBI_BE_WORD      4'h0
`define EBI_BE_IDLE      4'hF

// request size encoding from the core
`define EBI_SIZE_BYTE    2'h0
`define EBI_SIZE_HALF    2'h1
`define EBI_SIZE_WORD    2'h2

// reset values
`define EBI_TT_RST       8'h00
`define EBI_DATA_RST     32'h00000000

// turnaround idle cycles between the load and store halves of an atomic
`define EBI_TURN_CYCLES  1

`endif

// *** src/ebi_arbiter.v ***
`timescale 1ns/1ps
`default_nettype none
// external ownership handshake; the device owns the bus by default
module ebi_arbiter
(
	// clock and reset
	input  wire clk_sys,
	input  wire rst_n,
	// bus state from the sequencer
	input  wire bus_quiet,
	input  wire lock_active,
	// external ownership
	input  wire external_ownership_request,
	output reg  ownership_granted
);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ownership_granted <= 1'b0;
		else if (!external_ownership_request)
			ownership_granted <= 1'b0;
		else if (bus_quiet && !lock_active)
			ownership_granted <= 1'b1;
	end

endmodule
`default_nettype wire

// *** src/ebi_fault.v ***
`include "ebi_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// memory fault reporting and trap code keep
module ebi_fault
(
	// clock and reset
	input  wire                  clk_sys,
	input  wire                  rst_n,
	// completion from the sequencer
	input  wire                  done,
	input  wire                  fault,
	input  wire                  done_is_data,
	// halt code capture
	input  wire                  halt_error,
	input  wire [`EBI_TT_W-1:0]  halt_code,
	// to the execution core
	output reg                   data_access_exc,
	output reg                   instr_access_exc,
	output reg  [`EBI_TT_W-1:0]  trap_code_field
);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_access_exc  <= 1'b0;
			instr_access_exc <= 1'b0;
		end
		else
		begin
			data_access_exc  <= done && fault && done_is_data;
			instr_access_exc <= done && fault && !done_is_data;
		end
	end

	// no reset term: the code survives reset after an error halt with power kept
	always @(posedge clk_sys)
	begin
		if (halt_error)
			trap_code_field <= halt_code;
	end

endmodule
`default_nettype wire

// *** src/ebi_unit.v ***
`include "ebi_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module ebi_unit
(
	// clock and reset
	input  wire                   clk_sys,
	input  wire                   rst_n,
	// data request port
	input  wire                   dreq_valid,
	output wire                   dreq_ready,
	input  wire                   dreq_write,
	input  wire                   dreq_double,
	input  wire                   dreq_atomic,
	input  wire [1:0]             dreq_size,
	input  wire [1:0]             dreq_byte,
	input  wire [`EBI_ADR_W-1:0]  dreq_adr,
	input  wire [`EBI_ASI_W-1:0]  dreq_asi,
	input  wire [`EBI_DATA_W-1:0] dreq_wdata0,
	input  wire [`EBI_DATA_W-1:0] dreq_wdata1,
	// instruction request port
	input  wire                   ireq_valid,
	output wire                   ireq_ready,
	input  wire [`EBI_ADR_W-1:0]  ireq_adr,
	input  wire [`EBI_ASI_W-1:0]  ireq_asi,
	// response to the core
	output reg                    resp_valid,
	output reg                    resp_is_data,
	output reg                    resp_fault,
	output reg  [`EBI_DATA_W-1:0] resp_rdata,
	output wire                   data_access_exc,
	output wire                   instr_access_exc,
	// error halt capture
	input  wire                   halt_error,
	input  wire [`EBI_TT_W-1:0]   halt_code,
	output wire [`EBI_TT_W-1:0]   trap_code_field,
	// external bus
	output reg                    address_strobe_n,
	output reg                    read_not_write,
	output reg  [`EBI_BE_W-1:0]   byte_lane_enables_n,
	output reg  [`EBI_ADR_W-1:0]  adr,
	output reg  [`EBI_ASI_W-1:0]  space_identifier,
	output reg                    lock_n,
	output wire                   bus_oe,
	output reg  [`EBI_DATA_W-1:0] data_out,
	output reg                    data_oe,
	input  wire [`EBI_DATA_W-1:0] data_in,
	input  wire                   ready_n,
	input  wire                   memory_fault_in_n,
	// ownership
	input  wire                   external_ownership_request_n,
	output wire                   ownership_granted_n
);

	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_TURN = 2'h2;

	reg  [1:0]             state;
	reg  [1:0]             next_state;
	reg                    cur_data;
	reg                    cur_write;
	reg                    cur_double;
	reg                    cur_atomic;
	reg                    second;
	reg                    last_read;
	reg  [`EBI_BE_W-1:0]   cur_be;
	reg  [`EBI_DATA_W-1:0] cur_wdata1;
	reg                    wr_pending;
	wire                   granted;
	wire                   ready;
	wire                   fault;
	wire                   done;
	wire                   final_done;
	wire                   start_d;
	wire                   start_i;
	wire                   more;
	wire                   start_any;

	// lane enables for a data load or store of the given size and byte offset, active low
	function [`EBI_BE_W-1:0] be_code;
		input [1:0] size;
		input [1:0] offs;
		begin
			case (size)
				`EBI_SIZE_BYTE: be_code = ~(4'h8 >> offs);
				`EBI_SIZE_HALF: be_code = offs[1] ? 4'hC : 4'h3;
				default:        be_code = `EBI_BE_WORD;
			endcase
		end
	endfunction

	assign ready = !ready_n;
	assign fault = !memory_fault_in_n;
	assign done = (state == ST_WAIT) && ready;
	// second transfer of a double or atomic still to come
	assign more = (cur_double || cur_atomic) && !second;
	assign final_done = done && !more;
	assign start_d = (state == ST_IDLE) && !granted && dreq_valid;
	assign start_i = (state == ST_IDLE) && !granted && !dreq_valid && ireq_valid;
	assign dreq_ready = start_d;
	assign ireq_ready = start_i;
	assign bus_oe = !granted;

	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (start_d || start_i)
					next_state = ST_WAIT;
			ST_WAIT:
				if (done)
				begin
					if (!more)
						next_state = ST_IDLE;
					else if (cur_atomic)
						next_state = ST_TURN;
					else
						next_state = ST_WAIT;
				end
			ST_TURN:
				next_state = ST_WAIT;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state               <= ST_IDLE;
			cur_data            <= 1'b0;
			cur_write           <= 1'b0;
			cur_double          <= 1'b0;
			cur_atomic          <= 1'b0;
			second              <= 1'b0;
			last_read           <= 1'b0;
			cur_be              <= `EBI_BE_IDLE;
			cur_wdata1          <= `EBI_DATA_RST;
			wr_pending          <= 1'b0;
			address_strobe_n    <= 1'b1;
			read_not_write      <= 1'b1;
			byte_lane_enables_n <= `EBI_BE_IDLE;
			adr                 <= {`EBI_ADR_W{1'b0}};
			space_identifier    <= {`EBI_ASI_W{1'b0}};
			lock_n              <= 1'b1;
			data_out            <= `EBI_DATA_RST;
			data_oe             <= 1'b0;
			resp_valid          <= 1'b0;
			resp_is_data        <= 1'b0;
			resp_fault          <= 1'b0;
			resp_rdata          <= `EBI_DATA_RST;
		end
		else
		begin
			state            <= next_state;
			address_strobe_n <= 1'b1;
			resp_valid       <= 1'b0;
			if (start_d)
			begin
				cur_data   <= 1'b1;
				cur_write  <= dreq_write && !dreq_atomic;
				cur_double <= dreq_double && !dreq_atomic;
				cur_atomic <= dreq_atomic;
				second     <= 1'b0;
				cur_be     <= be_code(dreq_size, dreq_byte);
				cur_wdata1 <= dreq_atomic ? dreq_wdata0 : dreq_wdata1;
				address_strobe_n    <= 1'b0;
				adr                 <= dreq_adr;
				space_identifier    <= dreq_asi;
				read_not_write      <= !(dreq_write && !dreq_atomic);
				byte_lane_enables_n <= be_code(dreq_size, dreq_byte);
				lock_n              <= !dreq_atomic;
				data_out            <= dreq_wdata0;
				// a plain write drives data at once, even right after a read; only the
				// store half of an atomic waits for the idle turnaround cycle
				data_oe             <= dreq_write && !dreq_atomic;
				wr_pending          <= 1'b0;
			end
			else if (start_i)
			begin
				cur_data   <= 1'b0;
				cur_write  <= 1'b0;
				cur_double <= 1'b0;
				cur_atomic <= 1'b0;
				second     <= 1'b0;
				address_strobe_n    <= 1'b0;
				adr                 <= ireq_adr;
				space_identifier    <= ireq_asi;
				read_not_write      <= 1'b1;
				byte_lane_enables_n <= `EBI_BE_WORD;
				lock_n              <= 1'b1;
				data_oe             <= 1'b0;
			end
			else if (done)
			begin
				last_read  <= !cur_write;
				resp_valid <= 1'b1;
				resp_is_data <= cur_data;
				resp_fault <= fault;
				// faulted reads hand back zero rather than bus data
				resp_rdata <= (!cur_write && !fault) ? data_in : `EBI_DATA_RST;
				if (more && cur_double)
				begin
					// back-to-back second word of a double
					second           <= 1'b1;
					address_strobe_n <= 1'b0;
					adr              <= adr + {{(`EBI_ADR_W-1){1'b0}}, 1'b1};
					data_out         <= cur_wdata1;
				end
				else if (more && cur_atomic)
				begin
					// read half done: direction turns now, store follows the idle cycle
					second     <= 1'b1;
					wr_pending <= 1'b1;
					read_not_write <= 1'b0;
				end
				else
				begin
					// whole transaction over: release lanes, lock and data drivers
					read_not_write      <= 1'b1;
					byte_lane_enables_n <= `EBI_BE_IDLE;
					lock_n              <= 1'b1;
					data_oe             <= 1'b0;
				end
			end
			else if (state == ST_TURN && wr_pending)
			begin
				// store half of the atomic after the idle turnaround cycle
				wr_pending       <= 1'b0;
				address_strobe_n <= 1'b0;
				data_out         <= cur_wdata1;
				data_oe          <= 1'b1;
				byte_lane_enables_n <= cur_be;
			end
		end
	end

	// grant only from a quiet, unlocked bus
	ebi_arbiter u_arb
	(
		.clk_sys                    (clk_sys),
		.rst_n                      (rst_n),
		.bus_quiet                  ((state == ST_IDLE) && !start_any),
		.lock_active                (!lock_n),
		.external_ownership_request (!external_ownership_request_n),
		.ownership_granted          (granted)
	);

	// a request taken in the idle cycle goes ahead of the grant, so the grant
	// never lands on the edge that launches a strobe
	assign start_any = start_d || start_i;
	assign ownership_granted_n = !granted;

	ebi_fault u_fault
	(
		.clk_sys          (clk_sys),
		.rst_n            (rst_n),
		.done             (done),
		.fault            (fault),
		.done_is_data     (cur_data),
		.halt_error       (halt_error),
		.halt_code        (halt_code),
		.data_access_exc  (data_access_exc),
		.instr_access_exc (instr_access_exc),
		.trap_code_field  (trap_code_field)
	);

	// final_done marks the end of the whole transaction; no output carries it to the core
	wire unused_final;
	assign unused_final = final_done;

endmodule
`default_nettype wire

// *** test/ebi_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebi_monitor
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// core side
	input wire logic resp_fault,
	input wire logic data_access_exc,
	input wire logic instr_access_exc,
	// external bus
	input wire logic address_strobe_n,
	input wire logic read_not_write,
	input wire logic lock_n,
	input wire logic bus_oe,
	input wire logic data_oe,
	input wire logic ready_n,
	input wire logic memory_fault_in_n,
	input wire logic external_ownership_request_n,
	input wire logic ownership_granted_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	owned_start_a: assert property ($fell(address_strobe_n) |-> bus_oe && ownership_granted_n)
		else $error("strobe without bus");
	strobe_pulse_a: assert property ($fell(address_strobe_n) |=> address_strobe_n)
		else $error("strobe too long");
	read_dir_a: assert property (!address_strobe_n && read_not_write |-> read_not_write until !ready_n)
		else $error("read direction lost");
	write_data_a: assert property ($fell(address_strobe_n) && !read_not_write |-> data_oe)
		else $error("write data not driven");
	atomic_turn_a: assert property (!lock_n && read_not_write && !ready_n && memory_fault_in_n |=>
		address_strobe_n && !lock_n ##1 !address_strobe_n && !read_not_write && !lock_n)
		else $error("atomic turnaround wrong");
	lock_start_a: assert property ($fell(lock_n) |-> $fell(address_strobe_n))
		else $error("lock not with strobe");
	lock_grant_a: assert property (!lock_n |-> ownership_granted_n)
		else $error("grant while locked");
	grant_float_a: assert property (!ownership_granted_n |-> !bus_oe && !data_oe)
		else $error("drivers on while granted");
	grant_drop_a: assert property (!ownership_granted_n && external_ownership_request_n |=>
		ownership_granted_n)
		else $error("grant held after release");
	fault_trap_a: assert property (!ready_n && !memory_fault_in_n |=>
		resp_fault && data_access_exc != instr_access_exc)
		else $error("fault not reported");
endmodule
bind ebi_unit ebi_monitor mon (.*);
`default_nettype wire

// *** test/ebi_memory.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebi_memory
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// bus from the device
	input  wire logic        address_strobe_n,
	input  wire logic        read_not_write,
	input  wire logic [25:0] adr,
	input  wire logic [31:0] data_out,
	// behaviour chosen by the bench
	input  wire logic [1:0]  wait_cyc,
	input  wire logic        fault_en,
	// answer
	output logic             ready_n,
	output logic             memory_fault_in_n,
	output logic [31:0]      data_in
);
	logic [31:0] mem [16];
	logic [31:0] fault_data;
	logic [3:0]  a, fault_adr;
	logic [1:0]  cnt;
	logic        busy, rd, fault_rd;
	wire  [3:0]  i = address_strobe_n ? a : adr[3:0];
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 0;
			ready_n <= 1;
			memory_fault_in_n <= 1;
			data_in <= 32'h0;
		end
		else
		begin
			// released data lines never keep the last word
			data_in <= ~data_in;
			cnt <= address_strobe_n ? cnt - 2'h1 : wait_cyc - 2'h1;
			if (!address_strobe_n)
			begin
				busy <= 1;
				a <= adr[3:0];
				rd <= read_not_write;
			end
			if (!ready_n)
			begin
				ready_n <= 1;
				memory_fault_in_n <= 1;
				busy <= 0;
				if (!rd && memory_fault_in_n)
					mem[a] <= data_out;
				if (!memory_fault_in_n)
				begin
					fault_adr <= a;
					fault_data <= data_out;
					fault_rd <= rd;
				end
			end
			else if (busy ? cnt == 2'h0 : !address_strobe_n && wait_cyc == 2'h0)
			begin
				ready_n <= 0;
				memory_fault_in_n <= !fault_en;
				data_in <= mem[i];
			end
		end
	end
endmodule
`default_nettype wire

// *** test/external_bus_interface_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_interface_bench;
	logic clk_sys = 0, rst_n = 0, dreq_valid = 0, dreq_write = 0, dreq_double = 0;
	logic dreq_atomic = 0, ireq_valid = 0, halt_error = 0, fault_en = 0;
	logic external_ownership_request_n = 1;
	logic [1:0] dreq_size = 0, dreq_byte = 0, wait_cyc = 0;
	logic [3:0] dreq_asi = 0, ireq_asi = 0, space_identifier, byte_lane_enables_n;
	logic [7:0] halt_code = 0, trap_code_field;
	logic [25:0] dreq_adr = 0, ireq_adr = 0, adr;
	logic [31:0] dreq_wdata0 = 0, dreq_wdata1 = 0, data_in, data_out, resp_rdata;
	logic [31:0] shadow [16];
	logic dreq_ready, ireq_ready, resp_valid, resp_is_data, resp_fault, data_access_exc;
	logic instr_access_exc, address_strobe_n, read_not_write, lock_n, bus_oe, data_oe;
	logic ready_n, memory_fault_in_n, ownership_granted_n;
	int bad_count = 0, num_checks = 0;
	ebi_unit dut (.*);
	ebi_memory far (.*);
	initial forever #25 clk_sys = ~clk_sys;
	task automatic check(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		finish_test;
	end
	function automatic logic [31:0] expect_rd(input logic f, input logic [3:0] a);
		return f ? 32'h0 : shadow[a];
	endfunction
	// active-low lanes; byte 0 is the most significant lane
	function automatic logic [3:0] lanes(input logic [1:0] sz, o);
		case (sz)
			2'h0: return ~(4'h1 << (2'h3 - o));
			2'h1: return o[1] ? 4'hC : 4'h3;
			default: return 4'h0;
		endcase
	endfunction
	// waits for the next response of one port
	task automatic rsp(input logic id, f, rd, input logic [31:0] e);
		int n = 0;
		do @(negedge clk_sys); while ((resp_valid & resp_is_data == id) !== 1 && ++n < 60);
		check(resp_valid, 1);
		check(resp_fault, f);
		check(id ? data_access_exc : instr_access_exc, f);
		if (rd)
			check(resp_rdata, e);
	endtask
	task automatic xfer(input logic w, d, at, f, input logic [1:0] sz, input logic [3:0] a);
		logic [31:0] v [2];
		logic [3:0] b;
		logic rd;
		logic [1:0] o;
		int n = 0;
		v[0] = $urandom;
		v[1] = $urandom;
		a[0] = a[0] & !d;
		o = v[1][1:0] & {!sz[1], !sz};
		@(posedge clk_sys);
		fault_en <= f;
		wait_cyc <= v[1][9:8];
		dreq_valid <= 1;
		dreq_write <= w;
		dreq_double <= d;
		dreq_atomic <= at;
		dreq_size <= sz;
		dreq_byte <= o;
		dreq_adr <= {22'h0, a};
		dreq_asi <= v[1][7:4];
		dreq_wdata0 <= v[0];
		dreq_wdata1 <= v[1];
		do @(posedge clk_sys); while (dreq_ready !== 1 && ++n < 60);
		dreq_valid <= 0;
		@(negedge clk_sys);
		check(address_strobe_n, 0);
		check(space_identifier, v[1][7:4]);
		check(byte_lane_enables_n, lanes(sz, o));
		check(lock_n, !at);
		for (int k = 0; k <= (d | at); k++)
		begin
			b = at ? a : a + k[3:0];
			rd = at ? k == 0 : !w;
			rsp(1, f, rd, expect_rd(f, b));
			if (!rd && !f)
				shadow[b] = v[k & !at];
		end
	endtask
	task automatic ifetch(input logic [3:0] a);
		int n = 0;
		@(posedge clk_sys);
		ireq_valid <= 1;
		ireq_adr <= {22'h0, a};
		ireq_asi <= a;
		do @(posedge clk_sys); while (ireq_ready !== 1 && ++n < 60);
		check(dreq_valid, 0);
		ireq_valid <= 0;
		@(negedge clk_sys);
		check(space_identifier, a);
		check(byte_lane_enables_n, 4'h0);
		rsp(0, fault_en, 1, expect_rd(fault_en, a));
	endtask
	initial
	begin
		logic [31:0] x;
		void'($urandom(32'h1111));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1;
		for (int i = 0; i < 16; i += 2)
			xfer(1, 1, 0, 0, 2'h2, i[3:0]);
		for (int i = 0; i < 40; i++)
		begin
			x = $urandom;
			xfer(x[0] & !x[1], x[2] & !x[1], x[1], x[3] & x[4] & !x[1],
				{x[5], x[6] & !x[5]}, x[11:8]);
		end
		fork
			xfer(0, 0, 0, 0, 2'h2, 4'h3);
			ifetch(4'h5);
		join
		@(posedge clk_sys);
		fault_en <= 1;
		ifetch(4'h6);
		@(posedge clk_sys);
		external_ownership_request_n <= 0;
		fork
			begin
				repeat (2) @(posedge clk_sys);
				xfer(0, 0, 0, 0, 2'h2, 4'h7);
			end
			begin
				repeat (6) @(posedge clk_sys);
				check(ownership_granted_n, 0);
				check(dreq_ready, 0);
				external_ownership_request_n <= 1;
			end
		join
		// a request during a locked pair waits for the pair to finish
		fork
			xfer(0, 0, 1, 0, 2'h2, 4'h9);
			begin
				@(negedge address_strobe_n);
				@(posedge clk_sys);
				external_ownership_request_n <= 0;
			end
		join
		repeat (3) @(posedge clk_sys);
		check(ownership_granted_n, 0);
		external_ownership_request_n <= 1;
		repeat (2) @(posedge clk_sys);
		check(ownership_granted_n, 1);
		halt_error <= 1;
		halt_code <= 8'hA5;
		@(posedge clk_sys);
		halt_error <= 0;
		rst_n <= 0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1;
		@(posedge clk_sys);
		check(trap_code_field, 8'hA5);
		xfer(0, 0, 0, 0, 2'h2, 4'h3);
		finish_test;
	end
endmodule
`default_nettype wire
